// ==== adaptive_line_comb_separator.sv ====
/*
  Adaptive three-line luma/chroma separator with AHB-Lite control registers
  and an output FIFO.
  Assumes 8-bit composite and chroma samples arriving on the core clock
  with a valid strobe at the converter rate, and a decoder downstream.
*/
`timescale 1ns/1ps
module adaptive_line_comb_separator
  import comb_sep_pkg::*;
(
  input logic CLK,
  input logic RST,
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input logic [SMP_W-1:0] CVBS_IN,
  input logic [SMP_W-1:0] CHROMA_IN,
  input logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  output logic [SMP_W-1:0] LUMA_OUT,
  output logic [SMP_W-1:0] CHROMA_OUT,
  output logic OUT_VALID,
  input logic OUT_READY
);
  // ==========================================================
  // Arithmetic helpers
  function automatic logic signed [9:0] bpf(input logic [7:0] a, input logic [7:0] c);
    logic signed [9:0] d;
    d = $signed({2'b00, a}) - $signed({2'b00, c});
    return d >>> 1;
  endfunction

  function automatic logic [9:0] absd(input logic signed [9:0] v);
    return v[9] ? 10'(-v) : v;
  endfunction

  // Penalty to comb factor: no penalty gives full comb, large gives none
  function automatic logic [5:0] kfrom(input logic [9:0] pen);
    return (pen >= 10'(K_FULL)) ? 6'h00 : K_FULL - pen[5:0];
  endfunction

  function automatic logic [5:0] kscale(input logic [5:0] k, input logic [5:0] g);
    logic [11:0] p;
    p = k * g;
    return p[10:5];
  endfunction

  function automatic logic signed [9:0] blend(input logic signed [9:0] base,
                                              input logic signed [9:0] comb,
                                              input logic [5:0] k);
    logic signed [10:0] diff;
    logic signed [17:0] p;
    diff = $signed({comb[9], comb}) - $signed({base[9], base});
    p = diff * $signed({1'b0, k});
    p = p >>> 5;
    return base + p[9:0];
  endfunction

  function automatic logic [7:0] clip8(input logic signed [10:0] v);
    if (v < 0)
      return 8'h00;
    else if (v > 11'sh0FF)
      return 8'hFF;
    else
      return v[7:0];
  endfunction

  // ==========================================================
  // Register bus
  logic [31:0] ctrl_r;
  logic [31:0] gain_r;
  logic [PIX_W-1:0] len_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic wr_pend_r;
  logic [7:0] wa_r;
  logic [15:0] line_cnt_r;
  params_t act_r;
  params_t shadow;
  logic fifo_in_ready;
  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  assign addr_ok = HSEL & HREADY & HTRANS[1];
  assign rd_take = addr_ok & ~HWRITE;
  assign wr_take = addr_ok & HWRITE & (HSIZE == HSIZE_WORD);
  assign stat_word = (32'(line_cnt_r) << STAT_CNT_LSB) |
                     (32'(act_r.en) << STAT_EN_BIT) |
                     (32'(~fifo_in_ready) << STAT_STALL_BIT);
  assign rd_word = (HADDR[7:0] == CTRL_OFF) ? ctrl_r :
                   (HADDR[7:0] == GAIN_OFF) ? gain_r :
                   (HADDR[7:0] == LINE_OFF) ? 32'(len_r) :
                   (HADDR[7:0] == STAT_OFF) ? stat_word : 32'h0000_0000;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
      hresp_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= wr_take;
      wa_r <= HADDR[7:0];
      hrdata_r <= rd_take ? rd_word : 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r <= CTRL_RST;
      gain_r <= GAIN_RST;
      len_r <= LINE_RST;
    end
    else if (wr_pend_r)
    begin
      if (wa_r == CTRL_OFF)
        ctrl_r <= HWDATA;
      if (wa_r == GAIN_OFF)
        gain_r <= HWDATA;
      if (wa_r == LINE_OFF)
        len_r <= HWDATA[PIX_W-1:0];
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = hresp_r;

  // ==========================================================
  // Line timing and parameter shadowing
  logic [PIX_W-1:0] pix_r;
  logic adv;
  logic eol;

  assign shadow.en = ctrl_r[CTRL_EN_BIT];
  assign shadow.pal = ctrl_r[CTRL_PAL_BIT];
  assign shadow.boost = ctrl_r[CTRL_BOOST_BIT];
  assign shadow.cc = ctrl_r[CTRL_CC_BIT];
  assign shadow.daa = ctrl_r[CTRL_DAA_BIT];
  assign shadow.luma_comb_limit = ctrl_r[CTRL_LUMA_COMB_LIMIT_LSB +: 5];
  assign shadow.ky = gain_r[GAIN_KY_LSB +: 6];
  assign shadow.kc = gain_r[GAIN_KC_LSB +: 6];
  assign shadow.len = len_r;

  // Input only moves when the FIFO can take a result: the stall reaches the source
  assign adv = SAMPLE_VALID & fifo_in_ready;
  assign eol = pix_r == (act_r.len - PIX_W'(1));

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pix_r <= '0;
      line_cnt_r <= 16'h0000;
      act_r <= '{en: CTRL_RST[CTRL_EN_BIT], pal: CTRL_RST[CTRL_PAL_BIT],
                 boost: CTRL_RST[CTRL_BOOST_BIT], cc: CTRL_RST[CTRL_CC_BIT],
                 daa: CTRL_RST[CTRL_DAA_BIT], luma_comb_limit: CTRL_RST[CTRL_LUMA_COMB_LIMIT_LSB +: 5],
                 ky: GAIN_RST[GAIN_KY_LSB +: 6], kc: GAIN_RST[GAIN_KC_LSB +: 6],
                 len: LINE_RST};
    end
    else if (adv)
    begin
      pix_r <= eol ? '0 : pix_r + PIX_W'(1);
      if (eol)
      begin
        act_r <= shadow;
        line_cnt_r <= line_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Two line delays; slot 0 oldest line, 1 reference, 2 newest
  sample_t line_a [LINE_MAX];
  sample_t line_b [LINE_MAX];
  sample_t s0_r [3];
  sample_t d1_r [3];
  sample_t d2_r [3];
  logic v0_r;
  logic v1_r;
  logic v2_r;
  sample_t in_smp;

  assign in_smp = '{cvbs: CVBS_IN, chroma: CHROMA_IN};

  // Both fields ride the delays in every mode, so bypass keeps the latency
  always_ff @(posedge CLK)
  begin
    if (adv)
    begin
      line_a[pix_r] <= in_smp;
      line_b[pix_r] <= line_a[pix_r];
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < 3; i++)
      begin
        s0_r[i] <= '0;
        d1_r[i] <= '0;
        d2_r[i] <= '0;
      end
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end
    else if (adv)
    begin
      s0_r[0] <= line_b[pix_r];
      s0_r[1] <= line_a[pix_r];
      s0_r[2] <= in_smp;
      d1_r <= s0_r;
      d2_r <= d1_r;
      v0_r <= 1'b1;
      v1_r <= v0_r;
    end
  end

  // ==========================================================
  // Per-line subcarrier bandpass and lowpass, centred on tap 1
  logic signed [9:0] bp [3];
  logic [9:0] lp [3];

  for (genvar g = 0; g < 3; g++)
  begin : g_filt
    assign bp[g] = bpf(s0_r[g].cvbs, d2_r[g].cvbs);
    assign lp[g] = ({2'b00, s0_r[g].cvbs} + {1'b0, d1_r[g].cvbs, 1'b0} + {2'b00, d2_r[g].cvbs}) >> 2;
  end

  // ==========================================================
  // Adaptation
  logic signed [9:0] tn;
  logic signed [9:0] bn;
  logic signed [9:0] c_up;
  logic signed [9:0] c_dn;
  logic signed [9:0] c_2d;
  logic signed [9:0] comb_sel;
  logic [9:0] d_up;
  logic [9:0] d_dn;
  logic [9:0] dmin;
  logic [9:0] pen;
  logic [9:0] dv_up;
  logic [9:0] dv_dn;
  logic [9:0] dv;
  logic use_2d;
  logic rain_hit;
  logic [5:0] k_raw;
  logic [5:0] k_luma;
  logic [5:0] ky_g;
  logic [5:0] k_lim;
  logic [5:0] k_y;
  logic [5:0] kc_raw;
  logic [5:0] kc_src;
  logic [5:0] k_c;

  // Subcarrier flips line to line in NTSC; the standard bit re-aligns neighbours
  assign tn = act_r.pal ? -bp[0] : bp[0];
  assign bn = act_r.pal ? -bp[2] : bp[2];
  assign d_up = absd(bp[1] + tn);
  assign d_dn = absd(bp[1] + bn);
  assign c_up = (bp[1] - tn) >>> 1;
  assign c_dn = (bp[1] - bn) >>> 1;
  assign c_2d = (bp[1] + bp[1] - tn - bn) >>> 2;
  assign use_2d = (d_up < THR_2D) && (d_dn < THR_2D);
  assign comb_sel = use_2d ? c_2d : ((d_up <= d_dn) ? c_up : c_dn);
  assign dmin = (d_up <= d_dn) ? d_up : d_dn;
  // Stronger booster halves the penalty; more vertical detail, more hanging dots
  assign pen = act_r.boost ? (dmin >> 2) : (dmin >> 1);
  assign k_raw = kfrom(pen);
  // Uncorrelated noise on both neighbours looks like weak combing; damp it
  assign rain_hit = ~act_r.daa & (d_up > RAIN_THR) & (d_dn > RAIN_THR);
  assign k_luma = rain_hit ? (k_raw >> 1) : k_raw;
  assign ky_g = kscale(k_luma, act_r.ky);
  assign k_lim = K_FULL - {1'b0, act_r.luma_comb_limit};
  assign k_y = (ky_g > k_lim) ? k_lim : ky_g;
  assign dv_up = absd($signed(lp[1]) - $signed(lp[0]));
  assign dv_dn = absd($signed(lp[1]) - $signed(lp[2]));
  assign dv = (dv_up <= dv_dn) ? dv_up : dv_dn;
  assign kc_raw = kfrom(dv >> 1);
  assign kc_src = act_r.cc ? k_luma : kc_raw;
  assign k_c = kscale(kc_src, act_r.kc);

  // ==========================================================
  // Decision register
  logic signed [9:0] comb_r;
  logic signed [9:0] bp_r;
  logic [5:0] ky_r;
  logic [5:0] kc_r;
  sample_t mid_r;
  logic en_r;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      comb_r <= '0;
      bp_r <= '0;
      ky_r <= 6'h00;
      kc_r <= 6'h00;
      mid_r <= '0;
      en_r <= 1'b0;
      v2_r <= 1'b0;
    end
    else if (adv)
    begin
      comb_r <= comb_sel;
      bp_r <= bp[1];
      ky_r <= k_y;
      kc_r <= k_c;
      mid_r <= d1_r[1];
      en_r <= act_r.en;
      v2_r <= v1_r;
    end
  end

  // ==========================================================
  // Soft mix: factor 0 is plain bandpass/notch, full factor is full comb
  logic signed [9:0] chroma_c;
  logic signed [9:0] chroma_y;
  logic signed [10:0] luma_s;
  logic signed [10:0] chroma_s;
  sample_t result;
  sample_t fifo_q;
  logic push;

  assign chroma_c = blend(bp_r, comb_r, kc_r);
  assign chroma_y = blend(bp_r, comb_r, ky_r);
  assign luma_s = $signed({3'b000, mid_r.cvbs}) - $signed({chroma_y[9], chroma_y});
  assign chroma_s = CHROMA_BIAS + $signed({chroma_c[9], chroma_c});
  assign result = en_r ? sample_t'{cvbs: clip8(luma_s), chroma: clip8(chroma_s)} : mid_r;
  assign push = adv & v2_r;

  sample_fifo #(
    .W($bits(sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(result),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(fifo_q)
  );

  assign SAMPLE_READY = fifo_in_ready;
  assign LUMA_OUT = fifo_q.cvbs;
  assign CHROMA_OUT = fifo_q.chroma;
endmodule

// ==== comb_sep_asserts.sv ====
/*
  Port-level checker for the adaptive line comb separator.
  Assumes one clock domain and is attached to the top module by bind.
*/
`timescale 1ns/1ps
module comb_sep_checker
  import comb_sep_pkg::*;
(
  input logic CLK,
  input logic RST,
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  input logic [31:0] HRDATA,
  input logic HREADYOUT,
  input logic HRESP,
  input logic [SMP_W-1:0] CVBS_IN,
  input logic [SMP_W-1:0] CHROMA_IN,
  input logic SAMPLE_VALID,
  input logic SAMPLE_READY,
  input logic [SMP_W-1:0] LUMA_OUT,
  input logic [SMP_W-1:0] CHROMA_OUT,
  input logic OUT_VALID,
  input logic OUT_READY
);
  // ==========================================================
  // Decoded events
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  wire take = SAMPLE_VALID & SAMPLE_READY;
  wire pop = OUT_VALID & OUT_READY;
  wire rd_req = HSEL & HREADY & HTRANS[1] & ~HWRITE;
  // ==========================================================
  // Assertions
  // The first edge after release still sees the reset value, so skip it
  ready_after_rst_a: assert property (!$past(RST) |-> HREADYOUT)
    else $error("bus slave not ready");
  resp_okay_a: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  rdata_idle_a: assert property (HRDATA != 32'h0 |-> $past(rd_req))
    else $error("read data outside a read data phase");
  out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable({LUMA_OUT, CHROMA_OUT}))
    else $error("output word changed while stalled");
  full_stall_a: assert property (!SAMPLE_READY && !$past(RST) |-> OUT_VALID)
    else $error("input refused with empty output buffer");
  stall_hold_a: assert property (!SAMPLE_READY && !pop && !$past(RST) |=> !SAMPLE_READY)
    else $error("input freed without a pop");
  // The pipe moves only on a take and a pushed word shows one cycle later, so idle input keeps the output empty
  idle_no_out_a: assert property ((!take)[*3] ##0 !OUT_VALID |=> !OUT_VALID)
    else $error("output appeared without taken samples");
  ready_rise_a: assert property ($rose(SAMPLE_READY) && !$past(RST, 2) |-> $past(pop))
    else $error("input ready rose without a pop");
  cover property (rd_req);
  cover property (!SAMPLE_READY);
  cover property (pop ##1 pop);
endmodule

bind adaptive_line_comb_separator comb_sep_checker chk (
  .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .CVBS_IN(CVBS_IN), .CHROMA_IN(CHROMA_IN), .SAMPLE_VALID(SAMPLE_VALID),
  .SAMPLE_READY(SAMPLE_READY), .LUMA_OUT(LUMA_OUT), .CHROMA_OUT(CHROMA_OUT),
  .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY)
);

// ==== comb_sep_pkg.sv ====
/*
  Shared constants and carrier types for the adaptive line comb separator.
  Assumes a single 200 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package comb_sep_pkg;
  // ==========================================================
  // Sizes
  localparam int SMP_W = 8;
  localparam int LINE_MAX = 2048;
  localparam int PIX_W = 11;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] GAIN_OFF = 8'h04;
  localparam logic [7:0] LINE_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0C;
  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PAL_BIT = 1;
  localparam int CTRL_BOOST_BIT = 2;
  localparam int CTRL_CC_BIT = 3;
  localparam int CTRL_DAA_BIT = 4;
  localparam int CTRL_LUMA_COMB_LIMIT_LSB = 8;
  localparam int GAIN_KY_LSB = 0;
  localparam int GAIN_KC_LSB = 8;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_EN_BIT = 16;
  localparam int STAT_STALL_BIT = 17;
  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] GAIN_RST = 32'h0000_2020;
  localparam logic [PIX_W-1:0] LINE_RST = 11'h510;
  // ==========================================================
  // Adaptation constants
  localparam logic [5:0] K_FULL = 6'h20;
  localparam logic [9:0] THR_2D = 10'h010;
  localparam logic [9:0] RAIN_THR = 10'h030;
  localparam logic signed [10:0] CHROMA_BIAS = 11'sh080;
  // ==========================================================
  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [SMP_W-1:0] cvbs;
    logic [SMP_W-1:0] chroma;
  } sample_t;

  typedef struct packed {
    logic en;
    logic pal;
    logic boost;
    logic cc;
    logic daa;
    logic [4:0] luma_comb_limit;
    logic [5:0] ky;
    logic [5:0] kc;
    logic [PIX_W-1:0] len;
  } params_t;
endpackage

// ==== decoder_sink.sv ====
/*
  Behavioural colour decoder input: accepts luma/chroma pairs.
  Assumes the core clock; mode 0 always ready, 1 random stalls, 2 stopped.
*/
`timescale 1ns/1ps
module decoder_sink (
  input logic clk,
  input logic rst,
  input logic [1:0] mode,
  output logic ready
);
  logic [7:0] lf_r;
  // ==========================================================
  // Ready pattern
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lf_r <= 8'hA5;
      ready <= 1'b0;
    end
    else
    begin
      lf_r <= {lf_r[6:0], lf_r[7] ^ lf_r[5] ^ lf_r[4] ^ lf_r[3]};
      ready <= (mode == 2'h0) | ((mode == 2'h1) & lf_r[0]);
    end
  end
endmodule

// ==== sample_fifo.sv ====
/*
  Shift-register FIFO with valid/ready on both sides and registered flags.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input logic clk,
  input logic rst,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] widx;
  logic push;
  logic pop;

  // ==========================================================
  // Head always sits in slot 0 so the output is a flop
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign widx = pop ? cnt_r - ONE : cnt_r;
  assign cnt_nxt = cnt_r + (push ? ONE : '0) - (pop ? ONE : '0);
  assign out_data = mem_r[0];

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_nxt[i] = (pop && i < DEPTH - 1) ? mem_r[i + 1] : mem_r[i];
      if (push && widx == CW'(i))
      begin
        mem_nxt[i] = in_data;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
      cnt_r <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
      out_valid <= cnt_nxt != '0;
      in_ready <= cnt_nxt != FULL;
    end
  end
endmodule

// ==== tb_top.sv ====
/*
  Self-checking bench for the adaptive line comb separator.
  Assumes the design package, the decoder sink model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top
  import comb_sep_pkg::*;
;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  sample_t smp = '0;
  logic SAMPLE_VALID = 1'b0;
  logic SAMPLE_READY;
  logic [SMP_W-1:0] LUMA_OUT;
  logic [SMP_W-1:0] CHROMA_OUT;
  logic OUT_VALID;
  logic OUT_READY;
  logic [1:0] sink_mode = 2'h0;
  logic [31:0] seed = 32'h07AA;
  logic [31:0] rd;
  sample_t inq[$];
  sample_t outq[$];
  int n_fail = 0;
  int check_count = 0;
  // ==========================================================
  // Design and far side
  adaptive_line_comb_separator dut (
    .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE_WORD), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(), .CVBS_IN(smp.cvbs), .CHROMA_IN(smp.chroma),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .LUMA_OUT(LUMA_OUT),
    .CHROMA_OUT(CHROMA_OUT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY)
  );
  decoder_sink sink (.clk(CLK), .rst(RST), .mode(sink_mode), .ready(OUT_READY));
  initial
  begin
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    if (OUT_VALID === 1'b1 && OUT_READY === 1'b1)
      outq.push_back({LUMA_OUT, CHROMA_OUT});
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random data makes the matching shift unique
  function automatic int find_d();
    int hit;
    for (int d = 0; d < 64; d++)
    begin
      hit = 1;
      for (int j = outq.size() - 64; j < outq.size(); j++)
      begin
        if (j < d || outq[j] !== inq[j - d])
          hit = 0;
      end
      if (hit == 1)
        return d;
    end
    return -1;
  endfunction
  // Equal luma and chroma factors: the two outputs add back to the centre sample
  function automatic int find_sum();
    int hit;
    logic [8:0] s;
    for (int d = 0; d < 64; d++)
    begin
      hit = 1;
      for (int j = outq.size() - 32; j < outq.size(); j++)
      begin
        s = {1'b0, outq[j].cvbs} + {1'b0, outq[j].chroma} - 9'h080;
        if (j < d || s !== {1'b0, inq[j - d].cvbs})
          hit = 0;
      end
      if (hit == 1)
        return d;
    end
    return -1;
  endfunction
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic guard(input int t);
    if (t >= 500)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic bus_wait();
    int t;
    t = 0;
    do
    begin
      @(posedge CLK);
      t++;
    end
    while (HREADYOUT !== 1'b1 && t < 500);
    guard(t);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    bus_wait();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    bus_wait();
    rd = HRDATA;
  endtask
  task automatic take();
    int t;
    t = 0;
    do
    begin
      @(posedge CLK);
      t++;
    end
    while (SAMPLE_READY !== 1'b1 && t < 500);
    guard(t);
    inq.push_back(smp);
  endtask
  task automatic send(input int n, input logic flat, input logic [7:0] lv);
    for (int k = 0; k < n; k++)
    begin
      seed = lfsr(seed);
      // A non-zero level with random data keeps samples in a narrow band, so nothing clips
      smp <= flat ? {lv, 8'h80} : (lv != 8'h00) ? {lv + {2'b00, seed[5:0]}, seed[15:8]} : seed[15:0];
      SAMPLE_VALID <= 1'b1;
      take();
    end
    SAMPLE_VALID <= 1'b0;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    int t;
    int d16;
    int d24;
    logic [15:0] c1;
    logic [15:0] dl;
    logic [31:0] wv;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    bus(1'b0, CTRL_OFF, 32'h0);
    check("ctrl_reset", rd, CTRL_RST);
    bus(1'b0, GAIN_OFF, 32'h0);
    check("gain_reset", rd, GAIN_RST);
    bus(1'b0, LINE_OFF, 32'h0);
    check("line_reset", rd, {21'h0, LINE_RST});
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, LINE_OFF, 32'h10);
    bus(1'b1, CTRL_OFF, 32'h0);
    bus(1'b0, STAT_OFF, 32'h0);
    check("enable_held", {31'h0, rd[STAT_EN_BIT]}, 32'h1);
    sink_mode <= 2'h1;
    send(1400, 1'b0, 8'h0);
    bus(1'b0, STAT_OFF, 32'h0);
    check("enable_applied", {31'h0, rd[STAT_EN_BIT]}, 32'h0);
    c1 = rd[15:0];
    send(48, 1'b0, 8'h0);
    bus(1'b0, STAT_OFF, 32'h0);
    dl = rd[15:0] - c1;
    check("line_count", {16'h0, dl}, 32'h3);
    d16 = find_d();
    check("delay_over_line", d16, 32'h10);
    bus(1'b1, LINE_OFF, 32'h18);
    send(200, 1'b0, 8'h0);
    d24 = find_d();
    check("delay_step", d24 - d16, 32'h8);
    // Stopped sink: the buffer fills and the input is refused
    sink_mode <= 2'h2;
    seed = lfsr(seed);
    smp <= seed[15:0];
    SAMPLE_VALID <= 1'b1;
    repeat (40) @(posedge CLK);
    check("input_refused", {31'h0, SAMPLE_READY}, 32'h0);
    bus(1'b0, STAT_OFF, 32'h0);
    check("stall_flag", {31'h0, rd[STAT_STALL_BIT]}, 32'h1);
    sink_mode <= 2'h1;
    take();
    SAMPLE_VALID <= 1'b0;
    t = 0;
    while (OUT_VALID !== 1'b0 && t < 500)
    begin
      @(posedge CLK);
      t++;
    end
    guard(t);
    bus(1'b0, STAT_OFF, 32'h0);
    check("stall_clear", {31'h0, rd[STAT_STALL_BIT]}, 32'h0);
    // Flat field in every mode combination: no chroma, luma unchanged
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      wv = {19'h0, seed[4:0], 3'h0, i[3:0], 1'b1};
      bus(1'b1, CTRL_OFF, wv);
      bus(1'b1, GAIN_OFF, {18'h0, seed[13:8], 2'h0, seed[21:16]});
      bus(1'b0, CTRL_OFF, 32'h0);
      check("ctrl_fields", rd & 32'h1F1F, wv);
      send(100, 1'b1, 8'h60);
      check("flat_luma", {24'h0, outq[$].cvbs}, 32'h60);
      check("flat_chroma", {24'h0, outq[$].chroma}, 32'h80);
    end
    // Drained buffer realigns the queues: one line plus three taken samples apart
    t = 0;
    while (OUT_VALID !== 1'b0 && t < 500)
    begin
      @(posedge CLK);
      t++;
    end
    guard(t);
    inq.delete();
    outq.delete();
    seed = lfsr(seed);
    bus(1'b1, CTRL_OFF, {27'h0, seed[24], 1'b1, seed[26:25], 1'b1});
    bus(1'b1, GAIN_OFF, {18'h0, 1'b0, seed[4:0], 2'h0, 1'b0, seed[4:0]});
    send(200, 1'b0, 8'h60);
    check("split_sum", find_sum(), 32'h1B);
    end_sim();
  end
endmodule
